// *** verilog/aisc_pkg.sv ***
// constants and types of the analog input scaling curve block
package aisc_pkg;
  localparam int AW = 12;
  localparam int NCUR = 4;
  localparam int NPT = 20;
  localparam int NSRC = 42;
  // 0-3 ma, 4-23 di volt, 24-39 rtd, 40-41 card ma
  localparam logic [5:0] SRC_LAST = 6'h29;
  localparam logic signed [31:0] FRAC_MASK = 32'h0000_00ff;
  localparam logic signed [31:0] FRAC_HALF = 32'h0000_0080;
  localparam logic signed [31:0] ONE = 32'h0000_0100;
  localparam int CLK_NS = 8;
  localparam int STEP_NS = 5000000;
  localparam int TICK_CYC_DEF = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 20;
  localparam int STEP_MS = 5;
  localparam int TAU_DEF_MS = 1000;
  localparam int UPD_DEF_MS = 150;
  localparam int TAU_W = 20;
  localparam int UPD_W = 16;
  localparam logic [TAU_W-1:0] TAU_RST = TAU_W'(TAU_DEF_MS / STEP_MS);
  localparam logic [UPD_W-1:0] UPD_RST = UPD_W'(UPD_DEF_MS / STEP_MS);
  localparam logic [NPT-1:0] USED_RST = 20'h00003;
  localparam int DIV_N = 66;
  localparam int DIV_CW = 7;
  // offsets: block 0 global, block c+1 curve c
  localparam logic [7:0] OFF_GCTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TAU = 8'h04;
  localparam logic [7:0] OFF_UPD = 8'h08;
  localparam logic [7:0] OFF_MIN = 8'h0c;
  localparam logic [7:0] OFF_MAX = 8'h10;
  localparam logic [7:0] OFF_IN = 8'h14;
  localparam logic [7:0] OFF_OUT = 8'h18;
  localparam logic [7:0] OFF_USED = 8'h1c;
  localparam logic [7:0] OFF_PX = 8'h40;
  localparam logic [7:0] OFF_PY = 8'ha0;
  // control word fields
  localparam int CB_EN = 0;
  localparam int CB_FILT = 1;
  localparam int CB_OOR = 2;
  localparam int CB_HND = 4;
  localparam int CB_SRC = 8;
  localparam logic [1:0] HND_FLOAT = 2'h0;
  localparam logic [1:0] HND_FLOOR = 2'h1;
  localparam logic [1:0] HND_CEIL = 2'h2;
  localparam logic [1:0] HND_NEAR = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMP, ST_FDIV, ST_SCAN, ST_SEG, ST_IDIV, ST_STORE
  } aisc_st_e;
endpackage

// *** verilog/aisc_top.sv ***
// scaling curve engine with axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module aisc_top import aisc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC_DEF
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // axi4-lite write
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // measurement channels
  input wire logic [NSRC*32-1:0] MEAS_VALUE,
  input wire logic [NSRC-1:0] MEAS_VALID,
  // flags and interrupt
  output logic [NCUR-1:0] SCALING_OUT_OF_RANGE_FLAG,
  output logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  logic master_en_r;
  logic [NCUR-1:0] cen_r, filt_r, oor_en_r, eff_en, pend_v, flag_r;
  logic [1:0] hnd_r [NCUR];
  logic [5:0] src_r [NCUR];
  logic [TAU_W-1:0] tau_r [NCUR];
  logic [UPD_W-1:0] upd_r [NCUR];
  logic signed [31:0] min_r [NCUR];
  logic signed [31:0] max_r [NCUR];
  logic signed [31:0] in_r [NCUR];
  logic signed [31:0] out_r [NCUR];
  logic signed [31:0] flt_r [NCUR];
  logic [NPT-1:0] used_r [NCUR];
  logic signed [31:0] px_r [NCUR][NPT];
  logic signed [31:0] py_r [NCUR][NPT];
  logic [2*NCUR-1:0] stat_r, mask_r, ev_set;
  logic aw_full_r, w_full_r, wr_fire;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r, wval, rval;
  logic [3:0] wstrb_r;
  logic [3:0] wc;
  logic [7:0] wo;
  logic [1:0] wi;
  aisc_st_e st_r;
  logic [1:0] cur_r, nxt_cur;
  logic [4:0] pt_r, lo_r, hi_r;
  logic lo_ok_r, hi_ok_r, take, src_ok, oor_hit;
  logic signed [31:0] x_r, res_r, xs, in_cur, q;
  logic signed [31:0] pxi, pxl, pxh, pyl, pyh;
  logic [5:0] sidx, sel;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic div_busy_r, div_go, neg_r;
  logic [DIV_CW-1:0] div_cnt_r;
  logic [32:0] rem_r, den_r, dden;
  logic [33:0] rem_t;
  logic [DIV_N-1:0] quo_r;
  logic signed [DIV_N-1:0] dnum;

  assign eff_en = cen_r & {NCUR{master_en_r}};
  assign wr_fire = aw_full_r && w_full_r && !S_AXI_BVALID;
  assign wc = awaddr_r[11:8];
  assign wo = awaddr_r[7:0];
  assign wi = 2'(wc - 4'h1);

  // legal register address
  function automatic logic addr_ok(input logic [AW-1:0] a);
    logic [3:0] c;
    logic [7:0] o;
    c = a[11:8];
    o = a[7:0];
    if (a[1:0] != 2'b00) return 1'b0;
    if (c == 4'h0) return o <= OFF_MASK;
    if (c > 4'(NCUR)) return 1'b0;
    return (o <= OFF_USED) || (o >= OFF_PX && o < OFF_PX + 8'(4 * NPT))
      || (o >= OFF_PY && o < OFF_PY + 8'(4 * NPT));
  endfunction

  // register read view of one address
  function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
    logic [1:0] k;
    logic [7:0] o;
    k = 2'(a[11:8] - 4'h1);
    o = a[7:0];
    if (!addr_ok(a)) return 32'h0000_0000;
    if (a[11:8] == 4'h0) begin
      case (o)
        OFF_GCTRL: return {31'h0, master_en_r};
        OFF_STAT: return {24'h0, stat_r};
        default: return {24'h0, mask_r};
      endcase
    end
    case (o)
      OFF_CTRL: return {18'h0, src_r[k], 2'h0, hnd_r[k], 1'b0,
        oor_en_r[k], filt_r[k], cen_r[k]};
      OFF_TAU: return {12'h0, tau_r[k]};
      OFF_UPD: return {16'h0, upd_r[k]};
      OFF_MIN: return min_r[k];
      OFF_MAX: return max_r[k];
      OFF_IN: return in_r[k];
      OFF_OUT: return out_r[k];
      OFF_USED: return {12'h0, used_r[k]};
      default: begin
        if (o < OFF_PY) return px_r[k][5'((o - OFF_PX) >> 2)];
        return py_r[k][5'((o - OFF_PY) >> 2)];
      end
    endcase
  endfunction

  // read view and byte-merged write value
  always_comb begin
    rval = rd_word(S_AXI_ARADDR);
    wval = rd_word(awaddr_r);
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) wval[8*b +: 8] = wdata_r[8*b +: 8];
    end
  end

  // write address, data and response channels
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_r <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_r <= 1'b1;
        S_AXI_WREADY <= 1'b0;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read address and data channels
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rval;
      S_AXI_RRESP <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      master_en_r <= 1'b0;
      mask_r <= '0;
      cen_r <= '0;
      filt_r <= '0;
      oor_en_r <= '0;
      for (int c = 0; c < NCUR; c++) begin
        hnd_r[c] <= HND_FLOAT;
        src_r[c] <= '0;
        tau_r[c] <= TAU_RST;
        upd_r[c] <= UPD_RST;
        min_r[c] <= '0;
        max_r[c] <= '0;
        used_r[c] <= USED_RST;
        for (int i = 0; i < NPT; i++) begin
          px_r[c][i] <= (i == 1) ? ONE : '0;
          py_r[c][i] <= '0;
        end
      end
    end else if (wr_fire && addr_ok(awaddr_r)) begin
      if (wc == 4'h0) begin
        if (wo == OFF_GCTRL) master_en_r <= wval[0];
        if (wo == OFF_MASK) mask_r <= wval[2*NCUR-1:0];
      end else begin
        case (wo)
          OFF_CTRL: begin
            cen_r[wi] <= wval[CB_EN];
            filt_r[wi] <= wval[CB_FILT];
            oor_en_r[wi] <= wval[CB_OOR];
            hnd_r[wi] <= wval[CB_HND +: 2];
            src_r[wi] <= wval[CB_SRC +: 6];
          end
          OFF_TAU: tau_r[wi] <= wval[TAU_W-1:0];
          OFF_UPD: upd_r[wi] <= (wval[UPD_W-1:0] == '0) ?
            UPD_W'(1) : wval[UPD_W-1:0];
          OFF_MIN: min_r[wi] <= wval;
          OFF_MAX: max_r[wi] <= wval;
          OFF_USED: used_r[wi] <= wval[NPT-1:0] | USED_RST;
          OFF_IN, OFF_OUT: ;
          default: begin
            if (wo < OFF_PY) px_r[wi][5'((wo - OFF_PX) >> 2)] <= wval;
            else py_r[wi][5'((wo - OFF_PY) >> 2)] <= wval;
          end
        endcase
      end
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      stat_r <= '0;
      IRQ <= 1'b0;
    end else begin
      if (wr_fire && awaddr_r == {4'h0, OFF_STAT} && wstrb_r[0])
        stat_r <= (stat_r & ~wdata_r[2*NCUR-1:0]) | ev_set;
      else
        stat_r <= stat_r | ev_set;
      IRQ <= |(stat_r & mask_r);
    end
  end

  // 5 ms processing tick
  always_ff @(posedge CORE_CLK) begin
    if (!NRST || tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= NRST;
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      tick_r <= 1'b0;
    end
  end

  assign take = (st_r == ST_IDLE) && (|pend_v);

  // lowest pending curve first
  always_comb begin
    nxt_cur = '0;
    for (int i = NCUR - 1; i >= 0; i--) begin
      if (pend_v[i]) nxt_cur = 2'(i);
    end
  end

  // per-curve update cycle timers
  generate
    for (genvar g = 0; g < NCUR; g++) begin : g_tmr
      logic [UPD_W-1:0] cnt_r;
      logic pend_r;
      logic wrap;
      assign wrap = tick_r && (cnt_r == upd_r[g] - UPD_W'(1));
      assign pend_v[g] = pend_r;
      always_ff @(posedge CORE_CLK) begin
        if (!NRST || !eff_en[g]) begin
          cnt_r <= '0;
          pend_r <= 1'b0;
        end else begin
          if (tick_r) cnt_r <= wrap ? '0 : cnt_r + UPD_W'(1);
          if (wrap) pend_r <= 1'b1;
          else if (take && nxt_cur == 2'(g)) pend_r <= 1'b0;
        end
      end
    end
  endgenerate

  // source selection with hold on loss
  assign sidx = src_r[cur_r];
  assign sel = (sidx <= SRC_LAST) ? sidx : 6'h00;
  assign src_ok = (sidx <= SRC_LAST) && MEAS_VALID[sel];
  assign in_cur = in_r[cur_r];
  assign xs = src_ok ? signed'(MEAS_VALUE[32*sel +: 32]) : in_cur;
  assign pxi = px_r[cur_r][pt_r];
  assign pxl = px_r[cur_r][lo_r];
  assign pxh = px_r[cur_r][hi_r];
  assign pyl = py_r[cur_r][lo_r];
  assign pyh = py_r[cur_r][hi_r];
  assign oor_hit = oor_en_r[cur_r] &&
    (x_r < min_r[cur_r] || x_r > max_r[cur_r]);

  // divider operands: filter step or segment slope
  always_comb begin
    div_go = 1'b0;
    dnum = '0;
    dden = 33'h0_0000_0001;
    if (st_r == ST_SAMP && filt_r[cur_r]) begin
      // backward euler: y += (x - y) * dt / (dt + tau)
      div_go = 1'b1;
      dnum = DIV_N'(33'(xs) - 33'(flt_r[cur_r])) *
        DIV_N'(signed'({1'b0, upd_r[cur_r]}));
      dden = 33'(upd_r[cur_r]) + 33'(tau_r[cur_r]);
    end else if (st_r == ST_SEG && lo_ok_r && hi_ok_r) begin
      div_go = 1'b1;
      dnum = DIV_N'(33'(x_r) - 33'(pxl)) * DIV_N'(33'(pyh) - 33'(pyl));
      dden = unsigned'(33'(pxh) - 33'(pxl));
    end
  end

  // restoring divider, quotient truncated toward zero
  assign rem_t = {rem_r, quo_r[DIV_N-1]};
  assign q = neg_r ? -signed'(quo_r[31:0]) : signed'(quo_r[31:0]);
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      div_busy_r <= 1'b0;
      div_cnt_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      neg_r <= 1'b0;
    end else if (div_go) begin
      div_busy_r <= 1'b1;
      div_cnt_r <= DIV_CW'(DIV_N - 1);
      rem_r <= '0;
      quo_r <= dnum[DIV_N-1] ? unsigned'(-dnum) : unsigned'(dnum);
      den_r <= dden;
      neg_r <= dnum[DIV_N-1];
    end else if (div_busy_r) begin
      if (rem_t >= {1'b0, den_r}) begin
        rem_r <= 33'(rem_t - {1'b0, den_r});
        quo_r <= {quo_r[DIV_N-2:0], 1'b1};
      end else begin
        rem_r <= rem_t[32:0];
        quo_r <= {quo_r[DIV_N-2:0], 1'b0};
      end
      div_cnt_r <= div_cnt_r - DIV_CW'(1);
      if (div_cnt_r == '0) div_busy_r <= 1'b0;
    end
  end

  // curve sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      st_r <= ST_IDLE;
      cur_r <= '0;
      x_r <= '0;
      pt_r <= '0;
      lo_r <= '0;
      hi_r <= '0;
      lo_ok_r <= 1'b0;
      hi_ok_r <= 1'b0;
      res_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (take) begin
            cur_r <= nxt_cur;
            st_r <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          x_r <= xs;
          pt_r <= '0;
          lo_ok_r <= 1'b0;
          hi_ok_r <= 1'b0;
          st_r <= filt_r[cur_r] ? ST_FDIV : ST_SCAN;
        end
        ST_FDIV: begin
          if (!div_busy_r) begin
            x_r <= flt_r[cur_r] + q;
            st_r <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          // nearest used point at or below, and above
          if (used_r[cur_r][pt_r]) begin
            if (pxi <= x_r) begin
              if (!lo_ok_r || pxi > pxl) begin
                lo_r <= pt_r;
                lo_ok_r <= 1'b1;
              end
            end else if (!hi_ok_r || pxi < pxh) begin
              hi_r <= pt_r;
              hi_ok_r <= 1'b1;
            end
          end
          if (pt_r == 5'(NPT - 1)) st_r <= ST_SEG;
          else pt_r <= pt_r + 5'h01;
        end
        ST_SEG: begin
          // outside the curve: clamp to the end point
          if (!lo_ok_r) begin
            res_r <= pyh;
            st_r <= ST_STORE;
          end else if (!hi_ok_r) begin
            res_r <= pyl;
            st_r <= ST_STORE;
          end else begin
            st_r <= ST_IDIV;
          end
        end
        ST_IDIV: begin
          if (!div_busy_r) begin
            res_r <= pyl + q;
            st_r <= ST_STORE;
          end
        end
        ST_STORE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // output rounding
  function automatic logic signed [31:0] rnd(input logic signed [31:0] v,
      input logic [1:0] h);
    case (h)
      HND_FLOOR: return v & ~FRAC_MASK;
      HND_CEIL: return (v + FRAC_MASK) & ~FRAC_MASK;
      HND_NEAR: return (v + FRAC_HALF) & ~FRAC_MASK;
      default: return v;
    endcase
  endfunction

  // filter state, input and output views, flags
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      flag_r <= '0;
      for (int c = 0; c < NCUR; c++) begin
        flt_r[c] <= '0;
        in_r[c] <= '0;
        out_r[c] <= '0;
      end
    end else begin
      if (st_r == ST_SAMP && eff_en[cur_r]) begin
        in_r[cur_r] <= xs;
        if (!filt_r[cur_r]) flt_r[cur_r] <= xs;
      end
      if (st_r == ST_FDIV && !div_busy_r) flt_r[cur_r] <= flt_r[cur_r] + q;
      if (st_r == ST_STORE && eff_en[cur_r]) begin
        out_r[cur_r] <= rnd(res_r, hnd_r[cur_r]);
        flag_r[cur_r] <= oor_hit;
      end
      flag_r <= flag_r & eff_en;
      if (st_r == ST_STORE && eff_en[cur_r])
        flag_r[cur_r] <= oor_hit;
    end
  end

  // events: flag raised, output refreshed
  always_comb begin
    ev_set = '0;
    if (st_r == ST_STORE && eff_en[cur_r]) begin
      ev_set[cur_r] = oor_hit && !flag_r[cur_r];
      ev_set[NCUR + 32'(cur_r)] = 1'b1;
    end
  end

  // flag output register
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) SCALING_OUT_OF_RANGE_FLAG <= '0;
    else SCALING_OUT_OF_RANGE_FLAG <= flag_r & eff_en;
  end

  // checks
  property p_floor;
    st_r == ST_STORE && eff_en[cur_r] && hnd_r[cur_r] == HND_FLOOR |=>
      (out_r[cur_r] & FRAC_MASK) == 0 && out_r[cur_r] <= $past(res_r);
  endproperty
  a_floor: assert property (p_floor) else $error("floor wrong");
  property p_float;
    st_r == ST_STORE && eff_en[cur_r] && hnd_r[cur_r] == HND_FLOAT |=>
      out_r[cur_r] == $past(res_r);
  endproperty
  a_float: assert property (p_float) else $error("float wrong");
  property p_oor_lo;
    st_r == ST_STORE && eff_en[cur_r] && oor_en_r[cur_r] &&
      x_r < min_r[cur_r] |=> ##1 SCALING_OUT_OF_RANGE_FLAG[$past(cur_r, 2)];
  endproperty
  a_oor_lo: assert property (p_oor_lo) else $error("no flag");
  property p_oor_off;
    st_r == ST_STORE && !oor_en_r[cur_r] |=> !flag_r[cur_r];
  endproperty
  a_oor_off: assert property (p_oor_off) else $error("flag on");
  property p_dis;
    !eff_en[0] [*2] |-> !SCALING_OUT_OF_RANGE_FLAG[0] && !pend_v[0];
  endproperty
  a_dis: assert property (p_dis) else $error("idle curve active");
  property p_master;
    !master_en_r [*2] |-> pend_v == '0;
  endproperty
  a_master: assert property (p_master) else $error("pend while off");
  property p_hold;
    st_r == ST_SAMP && !src_ok |=> x_r == $past(in_cur) &&
      in_cur == $past(in_cur);
  endproperty
  a_hold: assert property (p_hold) else $error("lost not held");
  property p_raw;
    st_r == ST_SAMP && !filt_r[cur_r] |=> st_r == ST_SCAN &&
      x_r == $past(xs);
  endproperty
  a_raw: assert property (p_raw) else $error("raw altered");
  property p_div;
    $rose(div_busy_r) |-> ##65 div_busy_r ##1 !div_busy_r;
  endproperty
  a_div: assert property (p_div) else $error("divide length");
  property p_seg;
    st_r == ST_SEG && lo_ok_r && hi_ok_r |-> ##68 st_r == ST_STORE;
  endproperty
  a_seg: assert property (p_seg) else $error("interp late");
  property p_tick;
    $rose(pend_v[0]) |-> $past(tick_r);
  endproperty
  a_tick: assert property (p_tick) else $error("off tick");
  property p_bresp;
    wr_fire |=> S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no bvalid");
  property p_irq;
    (stat_r & mask_r) != '0 |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  c_interp: cover property (st_r == ST_IDIV ##1 st_r == ST_STORE);
  c_filter: cover property (st_r == ST_FDIV && !div_busy_r);
  c_flag: cover property ($rose(SCALING_OUT_OF_RANGE_FLAG[0]));
endmodule

// *** tb/aisc_meas_src.sv ***
// model of the option card measurement channels
`timescale 1ns/10ps
module aisc_meas_src import aisc_pkg::*; (
  // clock and set strobe
  input wire logic clk,
  input wire logic set,
  // source settings
  input wire logic [5:0] idx,
  input wire logic [31:0] val,
  input wire logic vld,
  // measurement lines
  output logic [NSRC*32-1:0] meas_value,
  output logic [NSRC-1:0] meas_valid
);
  logic [31:0] last_r [NSRC];
  logic [NSRC-1:0] vld_r = '0;
  // latch the value and validity of one source
  always @(posedge clk) begin
    if (set) begin
      last_r[idx] <= val;
      vld_r[idx] <= vld;
    end
  end
  // a lost source shows the inverse, never the held value
  always_comb begin
    for (int k = 0; k < NSRC; k++) begin
      meas_value[32*k +: 32] = vld_r[k] ? last_r[k] : ~last_r[k];
    end
    meas_valid = vld_r;
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the scaling curve block
`timescale 1ns/10ps
module testbench import aisc_pkg::*; ;
  logic CORE_CLK = 0, NRST = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
  logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0, set = 0;
  logic [AW-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0, val = '0, d;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [5:0] idx = '0;
  logic vld = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [31:0] S_AXI_RDATA;
  logic [NSRC*32-1:0] MEAS_VALUE;
  logic [NSRC-1:0] MEAS_VALID;
  logic [NCUR-1:0] SCALING_OUT_OF_RANGE_FLAG;
  logic [31:0] hx [4] = '{32'hc0, 32'h0, 32'h100, 32'h100};
  int mismatches = 0, checks = 0;
  aisc_top #(.TICK_CYCLES(20)) aisc_top_i (.CORE_CLK, .NRST, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MEAS_VALUE,
    .MEAS_VALID, .SCALING_OUT_OF_RANGE_FLAG, .IRQ);
  aisc_meas_src aisc_meas_src_i (.clk(CORE_CLK), .set, .idx, .val, .vld,
    .meas_value(MEAS_VALUE), .meas_valid(MEAS_VALID));
  // clock
  initial begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  function logic [11:0] ga(input logic [7:0] o);
    return {4'h0, o};
  endfunction
  function logic [11:0] ca(input logic [7:0] o);
    return {4'h1, o};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // axi4-lite write, each channel released when taken
  task wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= w;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    forever begin
      @(posedge CORE_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID) break;
    end
    S_AXI_BREADY <= 1'h0;
  endtask
  // axi4-lite read
  task rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] s);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    forever begin
      @(posedge CORE_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID) break;
    end
    q = S_AXI_RDATA;
    s = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask
  task rck(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  // set one measurement source in the model
  task src(input logic [31:0] v, input logic ok);
    @(posedge CORE_CLK);
    idx <= 6'h18;
    val <= v;
    vld <= ok;
    set <= 1'h1;
    @(posedge CORE_CLK);
    set <= 1'h0;
  endtask
  // wait for two output refreshes of curve 0
  task upd2;
    repeat (2) begin
      wr(ga(OFF_STAT), 32'hff);
      @(posedge CORE_CLK);
      while (IRQ !== 1'h1) @(posedge CORE_CLK);
    end
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge CORE_CLK);
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge CORE_CLK);
    NRST <= 1'h1;
    rck(ga(OFF_GCTRL), 32'h0);
    rck(ca(OFF_TAU), 32'hc8);
    rck(ca(OFF_UPD), 32'h1e);
    rck(ca(OFF_USED), 32'h3);
    rck(ca(OFF_PX + 8'h4), 32'h100);
    rd(ga(8'h0c), d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    src(32'h80, 1'h1);
    wr(ca(OFF_UPD), 32'h1);
    wr(ca(OFF_PY + 8'h4), 32'h180);
    wr(ga(OFF_MASK), 32'h10);
    wr(ga(OFF_GCTRL), 32'h1);
    for (int h = 0; h < 4; h++) begin
      wr(ca(OFF_CTRL), 32'h1801 | (h << 4));
      upd2;
      rck(ca(OFF_OUT), hx[h]);
    end
    rck(ca(OFF_IN), 32'h80);
    wr(ca(OFF_MIN), 32'h10);
    wr(ca(OFF_MAX), 32'h40);
    wr(ca(OFF_CTRL), 32'h1805);
    upd2;
    chk(32'(SCALING_OUT_OF_RANGE_FLAG[0]), 32'h1);
    src(32'h40, 1'h1);
    upd2;
    chk(32'(SCALING_OUT_OF_RANGE_FLAG[0]), 32'h0);
    src(32'h8, 1'h1);
    upd2;
    chk(32'(SCALING_OUT_OF_RANGE_FLAG[0]), 32'h1);
    wr(ca(OFF_USED), 32'h7);
    wr(ca(OFF_PX + 8'h8), 32'h200);
    src(32'h180, 1'h1);
    upd2;
    rck(ca(OFF_OUT), 32'hc0);
    src(32'h180, 1'h0);
    upd2;
    rck(ca(OFF_IN), 32'h180);
    wr(ca(OFF_TAU), 32'h2);
    wr(ca(OFF_CTRL), 32'h1807);
    src(32'h80, 1'h1);
    repeat (5000) @(posedge CORE_CLK);
    upd2;
    rck(ca(OFF_OUT), 32'hc3);
    rck(ca(OFF_IN), 32'h80);
    wr(ca(OFF_CTRL), 32'h1804);
    repeat (3) @(posedge CORE_CLK);
    chk(32'(SCALING_OUT_OF_RANGE_FLAG[0]), 32'h0);
    wr(ga(OFF_MASK), 32'h0);
    repeat (2) @(posedge CORE_CLK);
    chk(32'(IRQ), 32'h0);
    tally_and_finish;
  end
endmodule
